// [rtl/pvic_pkg.sv]
// package: constants and carriers for the prioritized vectored interrupt controller
package pvic_pkg;
  localparam int NUM_SRC = 82;
  localparam int VEC_W = 7;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 6;
  localparam int VBA_W = 14;
  localparam int FVH_W = 5;
  localparam int VADDR_W = VBA_W + VEC_W;
  localparam int NUM_PRIO_REG = 10;
  localparam int FIELDS_PER_REG = 8;
  // sources below this index are not programmable and sit at level 3
  localparam int FIXED_SRC = 2;
  localparam logic [1:0] FIXED_LEVEL = 2'h3;

  // register offsets (word addresses)
  localparam logic [ADDR_W-1:0] REG_PRIO_FIRST = 6'h00;
  localparam logic [ADDR_W-1:0] REG_PRIO_4 = 6'h04;
  localparam logic [ADDR_W-1:0] REG_PRIO_5 = 6'h05;
  localparam logic [ADDR_W-1:0] REG_VBA = 6'h0A;
  localparam logic [ADDR_W-1:0] REG_FAST_MATCH_REG_0 = 6'h0B;
  localparam logic [ADDR_W-1:0] REG_FVL0 = 6'h0C;
  localparam logic [ADDR_W-1:0] REG_FVH0 = 6'h0D;
  localparam logic [ADDR_W-1:0] REG_FAST_MATCH_REG_1 = 6'h0E;
  localparam logic [ADDR_W-1:0] REG_FVL1 = 6'h0F;
  localparam logic [ADDR_W-1:0] REG_FVH1 = 6'h10;
  localparam logic [ADDR_W-1:0] REG_CTRL = 6'h11;
  localparam logic [ADDR_W-1:0] REG_STATUS = 6'h12;

  // writable bits of the priority registers; the rest read zero
  localparam logic [DATA_W-1:0] PRIO_WMASK = 16'hFFFF;
  localparam logic [DATA_W-1:0] PRIO4_WMASK = 16'hFC3F;
  localparam logic [DATA_W-1:0] PRIO5_WMASK = 16'hFF3F;
  localparam logic [DATA_W-1:0] PRIO_RST = 16'h0000;

  // field positions in priority register 4 and 5
  localparam int PORT_A_PRIO_LSB = 4;
  localparam int PORT_B_PRIO_LSB = 2;
  localparam int PORT_C_PRIO_LSB = 0;
  localparam int DECODER1_INDEX_PRIO_LSB = 14;
  localparam int DECODER1_HOME_PRIO_LSB = 12;
  localparam int SERIAL1_RX_FULL_PRIO_LSB = 10;
  localparam int SERIAL1_RX_ERROR_PRIO_LSB = 8;
  localparam int SERIAL1_TX_IDLE_PRIO_LSB = 4;
  localparam int SERIAL1_TX_EMPTY_PRIO_LSB = 2;
  localparam int SYNC_SERIAL0_TX_PRIO_LSB = 0;

  // source numbers of the lines that may wake the core from stop
  localparam logic [VEC_W-1:0] SRC_EXT_A = 7'h02;
  localparam logic [VEC_W-1:0] SRC_EXT_B = 7'h03;
  localparam logic [VEC_W-1:0] SRC_CAN = 7'h04;

  // priority field codes and levels
  localparam logic [1:0] PRIO_OFF = 2'h0;
  localparam logic [1:0] LEVEL_FAST = 2'h2;

  // control register bits: falling-edge select for the two pins
  localparam int CTRL_EDGE_A_BIT = 0;
  localparam int CTRL_EDGE_B_BIT = 1;

  // current level codes
  localparam logic [1:0] CODE_NONE = 2'h0;
  localparam logic [1:0] CODE_TOP = 2'h3;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pvic_bus_req_t;

  typedef struct packed {
    logic req;
    logic fast;
    logic [1:0] level;
    logic [VEC_W-1:0] vector;
    logic [VADDR_W-1:0] addr;
  } pvic_core_req_t;
endpackage

// [rtl/pvic_prio_sel.sv]
// module: picks the highest-level eligible source, lowest number on a tie
`timescale 1ns/1ps
module pvic_prio_sel (
  input wire logic [pvic_pkg::NUM_SRC-1:0] elig_i,
  input wire logic [pvic_pkg::NUM_SRC-1:0][1:0] level_i,
  output logic found_o,
  output logic [pvic_pkg::VEC_W-1:0] vector_o,
  output logic [1:0] level_o
);
  always_comb
  begin
    found_o = 1'b0;
    vector_o = '0;
    level_o = 2'h0;
    // walking downward with >= lets the lower number win a tie
    for (int i = pvic_pkg::NUM_SRC - 1; i >= 0; i--)
    begin
      if (elig_i[i] && (!found_o || level_i[i] >= level_o))
      begin
        found_o = 1'b1;
        vector_o = i[pvic_pkg::VEC_W-1:0];
        level_o = level_i[i];
      end
    end
  end
endmodule

// [rtl/pvic_ctrl.sv]
// module: prioritized vectored interrupt controller with fast slots and wake-up
`timescale 1ns/1ps
module pvic_ctrl (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire pvic_pkg::pvic_bus_req_t bus_req_i,
  output logic [pvic_pkg::DATA_W-1:0] bus_rdata_o,
  input wire logic [pvic_pkg::NUM_SRC-1:0] irq_src_i,
  input wire logic ext_irq_pin_a_n_i,
  input wire logic ext_irq_pin_b_n_i,
  input wire logic [1:0] core_mask_i,
  input wire logic irq_ack_i,
  input wire logic irq_return_i,
  input wire logic wait_mode_i,
  input wire logic stop_mode_i,
  output pvic_pkg::pvic_core_req_t core_req_o,
  output logic [1:0] current_irq_level_o,
  output logic wake_req_o
);
  typedef struct packed {
    logic [pvic_pkg::NUM_PRIO_REG-1:0][pvic_pkg::DATA_W-1:0] prio;
    logic [pvic_pkg::VBA_W-1:0] vector_base_reg;
    logic [pvic_pkg::VEC_W-1:0] fast_match_reg_0;
    logic [pvic_pkg::VEC_W-1:0] fast_match_reg_1;
    logic [pvic_pkg::DATA_W-1:0] fvl0;
    logic [pvic_pkg::DATA_W-1:0] fvl1;
    logic [pvic_pkg::FVH_W-1:0] fvh0;
    logic [pvic_pkg::FVH_W-1:0] fvh1;
    logic [1:0] edge_sel;
    logic [1:0] pin_prev;
    logic [1:0] ext_pend;
    logic lp_prev;
    logic [pvic_pkg::NUM_SRC-1:0] wake_en;
    logic [1:0] cur_code;
    logic [pvic_pkg::DATA_W-1:0] rdata;
    logic wake;
    pvic_pkg::pvic_core_req_t core;
  } pvic_state_t;

  localparam pvic_state_t STATE_RST = '0;

  pvic_state_t state;
  pvic_state_t next_state;

  logic [pvic_pkg::NUM_SRC-1:0] src_req;
  logic [pvic_pkg::NUM_SRC-1:0] src_en;
  logic [pvic_pkg::NUM_SRC-1:0] src_elig;
  logic [pvic_pkg::NUM_SRC-1:0] stop_ok;
  logic [pvic_pkg::NUM_SRC-1:0][1:0] src_level;
  logic [1:0] gate_level;
  logic low_power;
  logic ext_a_req;
  logic ext_b_req;
  logic sel_found;
  logic [pvic_pkg::VEC_W-1:0] sel_vector;
  logic [1:0] sel_level;
  logic fast_hit0;
  logic fast_hit1;

  assign low_power = wait_mode_i | stop_mode_i;

  // edges need a running clock, so in low power the pins fall back to level
  assign ext_a_req = (state.edge_sel[pvic_pkg::CTRL_EDGE_A_BIT] && !low_power) ?
                     state.ext_pend[0] : ~ext_irq_pin_a_n_i;
  assign ext_b_req = (state.edge_sel[pvic_pkg::CTRL_EDGE_B_BIT] && !low_power) ?
                     state.ext_pend[1] : ~ext_irq_pin_b_n_i;

  // the stricter of core mask and current level sets the least level served
  assign gate_level = (core_mask_i > state.cur_code) ? core_mask_i : state.cur_code;

  genvar s;
  generate
    for (s = 0; s < pvic_pkg::NUM_SRC; s++)
    begin : g_src
      localparam int SRC_NUM = s;
      if (s < pvic_pkg::FIXED_SRC)
      begin : g_fixed
        assign src_en[s] = 1'b1;
        assign src_level[s] = pvic_pkg::FIXED_LEVEL;
      end
      else
      begin : g_prog
        localparam int FIDX = s - pvic_pkg::FIXED_SRC;
        localparam int RIDX = FIDX / pvic_pkg::FIELDS_PER_REG;
        localparam int BPOS = 2 * (FIDX % pvic_pkg::FIELDS_PER_REG);
        logic [1:0] field;
        assign field = state.prio[RIDX][BPOS +: 2];
        // 00 disables; 01..11 map to levels 0..2
        assign src_en[s] = (field != pvic_pkg::PRIO_OFF);
        assign src_level[s] = field - 2'h1;
      end
      if (SRC_NUM == int'(pvic_pkg::SRC_EXT_A))
      begin : g_ext_a
        assign src_req[s] = ext_a_req;
      end
      else if (SRC_NUM == int'(pvic_pkg::SRC_EXT_B))
      begin : g_ext_b
        assign src_req[s] = ext_b_req;
      end
      else
      begin : g_plain
        assign src_req[s] = irq_src_i[s];
      end
      // clocked peripherals are silent in stop; only these lines may wake it
      assign stop_ok[s] = (SRC_NUM == int'(pvic_pkg::SRC_EXT_A)) || (SRC_NUM == int'(pvic_pkg::SRC_EXT_B)) ||
                          (SRC_NUM == int'(pvic_pkg::SRC_CAN)) || !stop_mode_i;
      assign src_elig[s] = src_req[s] && src_en[s] && (src_level[s] >= gate_level);
    end
  endgenerate

  pvic_prio_sel u_sel (
    .elig_i(src_elig),
    .level_i(src_level),
    .found_o(sel_found),
    .vector_o(sel_vector),
    .level_o(sel_level)
  );

  // fast detection happens here so the core gets the handler address directly
  assign fast_hit0 = (sel_level == pvic_pkg::LEVEL_FAST) && (sel_vector == state.fast_match_reg_0);
  assign fast_hit1 = (sel_level == pvic_pkg::LEVEL_FAST) && (sel_vector == state.fast_match_reg_1);

  function automatic logic [pvic_pkg::DATA_W-1:0] prio_wmask(input int idx);
    logic [pvic_pkg::DATA_W-1:0] m;
    m = pvic_pkg::PRIO_WMASK;
    if (idx == int'(pvic_pkg::REG_PRIO_4))
    begin
      m = pvic_pkg::PRIO4_WMASK;
    end
    else if (idx == int'(pvic_pkg::REG_PRIO_5))
    begin
      m = pvic_pkg::PRIO5_WMASK;
    end
    return m;
  endfunction

  always_comb
  begin
    logic [1:0] ack_code;
    logic [1:0] falls;
    int ridx;
    next_state = state;
    ack_code = pvic_pkg::CODE_NONE;
    falls = state.pin_prev & ~{ext_irq_pin_b_n_i, ext_irq_pin_a_n_i};
    ridx = int'(bus_req_i.addr) - int'(pvic_pkg::REG_PRIO_FIRST);

    // register writes
    if (bus_req_i.wr)
    begin
      if (bus_req_i.addr < pvic_pkg::REG_PRIO_FIRST + pvic_pkg::NUM_PRIO_REG[pvic_pkg::ADDR_W-1:0])
      begin
        next_state.prio[ridx] = bus_req_i.wdata & prio_wmask(ridx);
      end
      case (bus_req_i.addr)
        pvic_pkg::REG_VBA: next_state.vector_base_reg = bus_req_i.wdata[pvic_pkg::VBA_W-1:0];
        pvic_pkg::REG_FAST_MATCH_REG_0: next_state.fast_match_reg_0 = bus_req_i.wdata[pvic_pkg::VEC_W-1:0];
        pvic_pkg::REG_FAST_MATCH_REG_1: next_state.fast_match_reg_1 = bus_req_i.wdata[pvic_pkg::VEC_W-1:0];
        pvic_pkg::REG_FVL0: next_state.fvl0 = bus_req_i.wdata;
        pvic_pkg::REG_FVL1: next_state.fvl1 = bus_req_i.wdata;
        pvic_pkg::REG_FVH0: next_state.fvh0 = bus_req_i.wdata[pvic_pkg::FVH_W-1:0];
        pvic_pkg::REG_FVH1: next_state.fvh1 = bus_req_i.wdata[pvic_pkg::FVH_W-1:0];
        pvic_pkg::REG_CTRL: next_state.edge_sel = bus_req_i.wdata[1:0];
        default: next_state.edge_sel = state.edge_sel;
      endcase
    end

    // register reads, answered one cycle after the strobe
    next_state.rdata = '0;
    if (bus_req_i.rd)
    begin
      if (bus_req_i.addr < pvic_pkg::REG_PRIO_FIRST + pvic_pkg::NUM_PRIO_REG[pvic_pkg::ADDR_W-1:0])
      begin
        next_state.rdata = state.prio[ridx];
      end
      case (bus_req_i.addr)
        pvic_pkg::REG_VBA: next_state.rdata = {2'h0, state.vector_base_reg};
        pvic_pkg::REG_FAST_MATCH_REG_0: next_state.rdata = {9'h000, state.fast_match_reg_0};
        pvic_pkg::REG_FAST_MATCH_REG_1: next_state.rdata = {9'h000, state.fast_match_reg_1};
        pvic_pkg::REG_FVL0: next_state.rdata = state.fvl0;
        pvic_pkg::REG_FVL1: next_state.rdata = state.fvl1;
        pvic_pkg::REG_FVH0: next_state.rdata = {11'h000, state.fvh0};
        pvic_pkg::REG_FVH1: next_state.rdata = {11'h000, state.fvh1};
        pvic_pkg::REG_CTRL: next_state.rdata = {14'h0000, state.edge_sel};
        pvic_pkg::REG_STATUS: next_state.rdata = {4'h0, state.cur_code, state.wake, state.core.req,
                                                  state.core.fast, state.core.vector};
        default: next_state.rdata = next_state.rdata;
      endcase
    end

    // falling-edge latches for the external pins; a new edge beats the ack clear
    next_state.pin_prev = {ext_irq_pin_b_n_i, ext_irq_pin_a_n_i};
    if (irq_ack_i && state.core.req && state.core.vector == pvic_pkg::SRC_EXT_A)
    begin
      next_state.ext_pend[0] = 1'b0;
    end
    if (irq_ack_i && state.core.req && state.core.vector == pvic_pkg::SRC_EXT_B)
    begin
      next_state.ext_pend[1] = 1'b0;
    end
    if (falls[0])
    begin
      next_state.ext_pend[0] = 1'b1;
    end
    if (falls[1])
    begin
      next_state.ext_pend[1] = 1'b1;
    end

    // current level: taken on ack, dropped on return from the exception
    case (state.core.level)
      2'h0: ack_code = 2'h1;
      2'h1: ack_code = 2'h2;
      default: ack_code = pvic_pkg::CODE_TOP;
    endcase
    if (irq_return_i)
    begin
      next_state.cur_code = pvic_pkg::CODE_NONE;
    end
    if (irq_ack_i && state.core.req)
    begin
      next_state.cur_code = ack_code;
    end

    // request to the core
    next_state.core.req = sel_found;
    next_state.core.level = sel_level;
    next_state.core.vector = sel_vector;
    next_state.core.fast = sel_found && (fast_hit0 || fast_hit1);
    if (fast_hit0)
    begin
      next_state.core.addr = {state.fvh0, state.fvl0};
    end
    else if (fast_hit1)
    begin
      next_state.core.addr = {state.fvh1, state.fvl1};
    end
    else
    begin
      next_state.core.addr = {state.vector_base_reg, sel_vector};
    end

    // enables are frozen on entry to wait or stop
    next_state.lp_prev = low_power;
    if (low_power && !state.lp_prev)
    begin
      next_state.wake_en = src_en;
    end
    // use the fresh snapshot so enables left from an earlier entry cannot wake
    next_state.wake = low_power && |(src_req & next_state.wake_en & stop_ok);
  end

  // reset leaves the controller in functional mode with all fields disabled
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= STATE_RST;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign bus_rdata_o = state.rdata;
  assign core_req_o = state.core;
  assign current_irq_level_o = state.cur_code;
  assign wake_req_o = state.wake;
endmodule

// [dv/pvic_ctrl_chk.sv]
// checker: port-level properties of the interrupt controller, bound to its top module
`timescale 1ns/1ps
module pvic_ctrl_chk (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire pvic_pkg::pvic_bus_req_t bus_req_i,
  input wire logic [pvic_pkg::DATA_W-1:0] bus_rdata_o,
  input wire logic [pvic_pkg::NUM_SRC-1:0] irq_src_i,
  input wire logic ext_irq_pin_a_n_i,
  input wire logic ext_irq_pin_b_n_i,
  input wire logic [1:0] core_mask_i,
  input wire logic irq_ack_i,
  input wire logic irq_return_i,
  input wire logic wait_mode_i,
  input wire logic stop_mode_i,
  input wire pvic_pkg::pvic_core_req_t core_req_o,
  input wire logic [1:0] current_irq_level_o,
  input wire logic wake_req_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  function automatic logic [1:0] code_of(input logic [1:0] l);
    return (l == 2'h0) ? 2'h1 : ((l == 2'h1) ? 2'h2 : 2'h3);
  endfunction
  sequence s_taken;
    irq_ack_i && core_req_o.req;
  endsequence
  sequence s_bare_return;
    irq_return_i && !irq_ack_i;
  endsequence
  rd_idle_zero_a: assert property (!$past(bus_req_i.rd) |-> bus_rdata_o == '0)
    else $error("read data not zero while idle");
  rd_unmapped_a: assert property (
    $past(bus_req_i.rd && bus_req_i.addr > pvic_pkg::REG_STATUS) |-> bus_rdata_o == '0)
    else $error("unmapped read not zero");
  prio4_resv_a: assert property (
    $past(bus_req_i.rd && bus_req_i.addr == pvic_pkg::REG_PRIO_4) |-> bus_rdata_o[9:6] == '0)
    else $error("reserved bits of priority register 4 not zero");
  prio5_resv_a: assert property (
    $past(bus_req_i.rd && bus_req_i.addr == pvic_pkg::REG_PRIO_5) |-> bus_rdata_o[7:6] == '0)
    else $error("reserved bits of priority register 5 not zero");
  mask_gate_a: assert property (
    core_req_o.req |-> core_req_o.level >= $past(core_mask_i) && core_req_o.level >= $past(current_irq_level_o))
    else $error("request below mask or current level");
  fast_level_a: assert property (
    core_req_o.fast |-> core_req_o.req && core_req_o.level == pvic_pkg::LEVEL_FAST)
    else $error("fast request not at level 2");
  normal_addr_a: assert property (
    core_req_o.req && !core_req_o.fast |-> core_req_o.addr[pvic_pkg::VEC_W-1:0] == core_req_o.vector)
    else $error("normal vector address does not end in vector number");
  ack_level_a: assert property (
    s_taken |=> current_irq_level_o == code_of($past(core_req_o.level)))
    else $error("current level code wrong after acknowledge");
  return_clear_a: assert property (s_bare_return |=> current_irq_level_o == pvic_pkg::CODE_NONE)
    else $error("current level not cleared on return");
  wake_lowpwr_a: assert property (wake_req_o |-> $past(wait_mode_i || stop_mode_i))
    else $error("wake request outside low power");
endmodule

bind pvic_ctrl pvic_ctrl_chk u_chk (
  .ref_clk_i, .rst_i, .bus_req_i, .bus_rdata_o, .irq_src_i, .ext_irq_pin_a_n_i, .ext_irq_pin_b_n_i,
  .core_mask_i, .irq_ack_i, .irq_return_i, .wait_mode_i, .stop_mode_i, .core_req_o,
  .current_irq_level_o, .wake_req_o
);

// [dv/pvic_core_model.sv]
// partner model: core side that takes presented requests and later returns
`timescale 1ns/1ps
module pvic_core_model (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic slow_i,
  input wire logic req_i,
  output logic ack_o,
  output logic ret_o
);
  logic [3:0] cnt;
  logic busy;
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt <= 4'h0;
      busy <= 1'b0;
      ack_o <= 1'b0;
      ret_o <= 1'b0;
    end
    else
    begin
      ack_o <= 1'b0;
      ret_o <= 1'b0;
      cnt <= (busy || (en_i && req_i)) ? cnt + 4'h1 : 4'h0;
      // fetch at the vector takes one or four cycles; never a subroutine jump
      if (!busy && en_i && req_i && cnt >= (slow_i ? 4'h4 : 4'h1))
      begin
        ack_o <= 1'b1;
        busy <= 1'b1;
        cnt <= 4'h0;
      end
      // handler finishes even if disabled meanwhile, so the level never sticks
      if (busy && cnt == 4'h6)
      begin
        ret_o <= 1'b1;
        busy <= 1'b0;
        cnt <= 4'h0;
      end
    end
  end
endmodule

// [dv/prioritized_vectored_irq_controller_tb.sv]
// testbench: registers, priority selection, fast slots, nesting and wake-up
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin n_mismatch++; \
  $display("unexpected %s exp %0h got %0h", nm, ex, gt); end end
module prioritized_vectored_irq_controller_tb;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  pvic_pkg::pvic_bus_req_t bus_req = '0;
  logic [81:0] src = '0;
  logic pin_a_n = 1'b1;
  logic pin_b_n = 1'b1;
  logic [1:0] mask = 2'h0;
  logic wait_m = 1'b0;
  logic stop_m = 1'b0;
  logic m_en = 1'b0;
  logic m_slow = 1'b0;
  logic [15:0] rdata;
  logic ack;
  logic ret;
  logic [1:0] cur;
  logic wake;
  pvic_pkg::pvic_core_req_t creq;
  int n_mismatch = 0;
  int n_tests = 0;
  int seed = 45904;
  int x;
  int k;
  logic [15:0] pr [10];
  logic [13:0] vector_base_reg;
  logic [15:0] d;
  logic [95:0] r;
  logic [95:0] q;
  logic [9:0] e;
  always #2 ref_clk_i = ~ref_clk_i;
  pvic_ctrl u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_req_i(bus_req), .bus_rdata_o(rdata),
    .irq_src_i(src), .ext_irq_pin_a_n_i(pin_a_n), .ext_irq_pin_b_n_i(pin_b_n), .core_mask_i(mask),
    .irq_ack_i(ack), .irq_return_i(ret), .wait_mode_i(wait_m), .stop_mode_i(stop_m),
    .core_req_o(creq), .current_irq_level_o(cur), .wake_req_o(wake));
  pvic_core_model u_core (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .en_i(m_en), .slow_i(m_slow),
    .req_i(creq.req), .ack_o(ack), .ret_o(ret));
  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    @(posedge ref_clk_i);
    bus_req <= '{1'b1, 1'b0, a, v};
    @(posedge ref_clk_i);
    bus_req <= '0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge ref_clk_i);
    bus_req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge ref_clk_i);
    bus_req <= '0;
    #1 d = rdata;
  endtask
  task automatic wp(input int n, input logic [15:0] v);
    pr[n] = v & ((n == 4) ? pvic_pkg::PRIO4_WMASK : ((n == 5) ? pvic_pkg::PRIO5_WMASK : pvic_pkg::PRIO_WMASK));
    wr(6'(n), v);
  endtask
  // returns {found, level, vector}; a field of 00 decrements to 3, which marks it off
  function automatic logic [9:0] exp_sel(input logic [81:0] s, input logic [1:0] m);
    logic [9:0] b;
    logic [1:0] f;
    b = '0;
    for (int n = 81; n >= 0; n--)
    begin
      f = (n < 2) ? 2'h3 : pr[(n - 2) / 8][2 * ((n - 2) % 8) +: 2] - 2'h1;
      if (s[n] && (n < 2 || f != 2'h3) && f >= m && (!b[9] || f >= b[8:7]))
        b = {1'b1, f, 7'(n)};
    end
    return b;
  endfunction
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #40000;
    n_mismatch++;
    print_verdict();
  end
  initial
  begin
    for (int n = 0; n < 10; n++)
      pr[n] = 16'h0000;
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd(pvic_pkg::REG_PRIO_5);
    `CHK("prio5 reset", pvic_pkg::PRIO_RST, d)
    wr(6'h3F, 16'hFFFF);
    rd(6'h3F);
    `CHK("unmapped", 16'h0000, d)
    x = $random(seed);
    vector_base_reg = x[13:0];
    wr(pvic_pkg::REG_VBA, {2'h0, vector_base_reg});
    for (int i = 0; i < 150; i++)
    begin
      x = $random(seed);
      k = x[19:16] % 10;
      wp(k, x[15:0]);
      rd(6'(k));
      `CHK("prio reg", pr[k], d)
      r = {$random(seed), $random(seed), $random(seed)};
      q = {$random(seed), $random(seed), $random(seed)};
      @(posedge ref_clk_i);
      src <= r[81:0] & q[81:0] & ~82'hC;
      mask <= x[31:30];
      @(posedge ref_clk_i);
      #1 e = exp_sel(src, mask);
      `CHK("req", e[9], creq.req)
      if (e[9])
      begin
        `CHK("level", e[8:7], creq.level)
        `CHK("vector", e[6:0], creq.vector)
        `CHK("addr", {vector_base_reg, e[6:0]}, creq.addr)
      end
    end
    for (int sl = 0; sl < 2; sl++)
    begin
      wp(2, 16'h0030);
      wr(pvic_pkg::REG_FAST_MATCH_REG_0, (sl == 1) ? 16'h0015 : 16'h0014);
      wr(pvic_pkg::REG_FAST_MATCH_REG_1, 16'h0014);
      wr((sl == 1) ? pvic_pkg::REG_FVL1 : pvic_pkg::REG_FVL0, (sl == 1) ? 16'h5A3C : 16'hA5C3);
      wr((sl == 1) ? pvic_pkg::REG_FVH1 : pvic_pkg::REG_FVH0, 16'h0015);
      @(posedge ref_clk_i);
      src <= 82'h1 << 20;
      mask <= 2'h0;
      @(posedge ref_clk_i);
      #1 `CHK("fast", 1'b1, creq.fast)
      `CHK("fast addr", {5'h15, (sl == 1) ? 16'h5A3C : 16'hA5C3}, creq.addr)
    end
    wp(2, 16'h0020);
    @(posedge ref_clk_i);
    #1 `CHK("fast off", 1'b0, creq.fast)
    `CHK("normal addr", {vector_base_reg, 7'h14}, creq.addr)
    @(posedge ref_clk_i);
    m_slow <= 1'b1;
    m_en <= 1'b1;
    for (int w = 0; w < 20 && ack !== 1'b1; w++)
      @(posedge ref_clk_i) #1;
    @(posedge ref_clk_i);
    m_en <= 1'b0;
    #1 `CHK("level code", 2'h2, cur)
    @(posedge ref_clk_i);
    #1 `CHK("nested req", 1'b0, creq.req)
    for (int w = 0; w < 20 && ret !== 1'b1; w++)
      @(posedge ref_clk_i) #1;
    @(posedge ref_clk_i);
    src <= '0;
    #1 `CHK("level cleared", 2'h0, cur)
    @(posedge ref_clk_i);
    src <= 82'h1 << 20;
    wait_m <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1 `CHK("wake wait", 1'b1, wake)
    @(posedge ref_clk_i);
    wait_m <= 1'b0;
    src <= '0;
    repeat (2) @(posedge ref_clk_i);
    wait_m <= 1'b1;
    wp(2, 16'h0060);
    @(posedge ref_clk_i);
    src <= 82'h1 << 21;
    repeat (3) @(posedge ref_clk_i);
    #1 `CHK("wake late enable", 1'b0, wake)
    @(posedge ref_clk_i);
    wait_m <= 1'b0;
    src <= '0;
    wr(pvic_pkg::REG_CTRL, 16'h0003);
    wp(0, 16'h0005);
    @(posedge ref_clk_i);
    stop_m <= 1'b1;
    src <= 82'h1 << 20;
    repeat (3) @(posedge ref_clk_i);
    #1 `CHK("wake stop clocked", 1'b0, wake)
    @(posedge ref_clk_i);
    pin_a_n <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1 `CHK("wake stop pin", 1'b1, wake)
    @(posedge ref_clk_i);
    pin_a_n <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1 `CHK("wake pin released", 1'b0, wake)
    @(posedge ref_clk_i);
    pin_b_n <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1 `CHK("wake stop pin b", 1'b1, wake)
    @(posedge ref_clk_i);
    stop_m <= 1'b0;
    pin_b_n <= 1'b1;
    src <= '0;
    repeat (2) @(posedge ref_clk_i);
    #1 `CHK("edge latched", 1'b1, creq.req)
    `CHK("edge vector", pvic_pkg::SRC_EXT_A, creq.vector)
    print_verdict();
  end
endmodule
